// ==== ipma_addr_form.sv ====
// address former: pointer high part joined with low word, optional buffer start
// assumes purely combinational use inside the generator
`timescale 1ns/1ps
module ipma_addr_form
   import ipma_pkg::*;
(
   input wire ipma_ptr_t ptrIn,
   input wire logic circularEn,
   input wire logic [`IPMA_LOW_W-1:0] circularBufferStart,
   output ipma_ptr_t addrOut
);
   logic [`IPMA_LOW_W-1:0] lowSum;
   // low word offset by buffer start when circular
   assign lowSum = circularEn ? ptrIn[`IPMA_LOW_W-1:0] + circularBufferStart
                              : ptrIn[`IPMA_LOW_W-1:0];
   assign addrOut = {ptrIn[`IPMA_PTR_W-1:`IPMA_LOW_W], lowSum};
endmodule

// ==== ipma_agen.sv ====
// indirect pointer-modify address generator for memory-mapped register access
// assumes one request at a time from decode; accepted only while ready is high
//
// Contract
// - word pre-decrement: pointer minus 1, used, kept
// - long pre-decrement: pointer minus 2, used, kept
// - address is high part with low word (+start)
// - second word at first plus/minus one by parity
// - post-add, legacy off: add index register zero
// - post-sub, legacy off: subtract index register zero
// - post-add, legacy on: add extended aux zero
// - post-sub, legacy on: subtract extended aux zero
// - post modes: offset never scaled by width
`timescale 1ns/1ps
`include "ipma_map.svh"
module ipma_agen
   import ipma_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic reqValid,
   input wire logic [1:0] reqMode,
   input wire logic reqLong,
   input wire logic legacy_compat_mode,
   input wire logic circularEn,
   input wire logic [`IPMA_LOW_W-1:0] circular_buffer_start,
   input wire ipma_ptr_t extended_aux_pointer,
   input wire logic [`IPMA_LOW_W-1:0] index_register_zero,
   input wire ipma_ptr_t extended_aux_register_zero,
   output logic reqReady,
   output logic addrValid,
   output logic addrSecond,
   output ipma_ptr_t dataAddr,
   output logic ptrWrEn,
   output ipma_ptr_t ptrNew
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ipma_state_t st;
      logic rdy;
      logic av;
      logic sec;
      ipma_ptr_t addr;
      logic we;
      ipma_ptr_t ptr;
   } ipma_reg_t;

   ipma_reg_t cur_q;
   ipma_reg_t nxt_d;
   ipma_ptr_t basePtr;
   ipma_ptr_t offset;
   ipma_ptr_t updated;
   ipma_ptr_t formed;

   // ----------------------------------------
   // pointer arithmetic
   // ----------------------------------------
   always_comb begin
      offset = reqLong ? `IPMA_STEP_LONG : `IPMA_STEP_WORD;
      updated = extended_aux_pointer;
      basePtr = extended_aux_pointer;
      case (reqMode)
         `IPMA_MODE_PREDEC: begin
            updated = extended_aux_pointer - offset;
            basePtr = updated;
         end
         `IPMA_MODE_POSTADD: begin
            if (legacy_compat_mode) begin
               updated = extended_aux_pointer + extended_aux_register_zero;
            end else begin
               updated = extended_aux_pointer
                  + {{(`IPMA_PTR_W-`IPMA_LOW_W){1'b0}}, index_register_zero};
            end
         end
         `IPMA_MODE_POSTSUB: begin
            if (legacy_compat_mode) begin
               updated = extended_aux_pointer - extended_aux_register_zero;
            end else begin
               updated = extended_aux_pointer
                  - {{(`IPMA_PTR_W-`IPMA_LOW_W){1'b0}}, index_register_zero};
            end
         end
         default: begin
            updated = extended_aux_pointer;
         end
      endcase
   end

   ipma_addr_form uForm (
      .ptrIn(basePtr),
      .circularEn(circularEn),
      .circularBufferStart(circular_buffer_start),
      .addrOut(formed)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      nxt_d = cur_q;
      nxt_d.av = 1'b0;
      nxt_d.sec = 1'b0;
      nxt_d.we = 1'b0;
      case (cur_q.st)
         IPMA_IDLE: begin
            nxt_d.rdy = 1'b1;
            // mode 3 is no operation and is never taken
            if (reqValid && cur_q.rdy && reqMode != 2'h3) begin
               nxt_d.av = 1'b1;
               nxt_d.addr = formed;
               nxt_d.we = 1'b1;
               nxt_d.ptr = updated;
               if (reqLong) begin
                  nxt_d.st = IPMA_SECOND;
                  nxt_d.rdy = 1'b0;
               end
            end
         end
         IPMA_SECOND: begin
            // pointer already written back; only the paired word goes out
            nxt_d.av = 1'b1;
            nxt_d.sec = 1'b1;
            nxt_d.addr = cur_q.addr[0] ? cur_q.addr - `IPMA_STEP_WORD
                                       : cur_q.addr + `IPMA_STEP_WORD;
            nxt_d.st = IPMA_IDLE;
            nxt_d.rdy = 1'b1;
         end
         default: begin
            nxt_d.st = IPMA_IDLE;
            nxt_d.rdy = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cur_q <= '{st: IPMA_IDLE, rdy: 1'b0, av: 1'b0, sec: 1'b0,
                    addr: `IPMA_PTR_RESET, we: 1'b0, ptr: `IPMA_PTR_RESET};
      end else begin
         cur_q <= nxt_d;
      end
   end

   assign reqReady = cur_q.rdy;
   assign addrValid = cur_q.av;
   assign addrSecond = cur_q.sec;
   assign dataAddr = cur_q.addr;
   assign ptrWrEn = cur_q.we;
   assign ptrNew = cur_q.ptr;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   logic accept;
   assign accept = reqValid && reqReady && reqMode != 2'h3;

   AST_PREDEC_WORD: assert property (accept && reqMode == 2'h0 && !reqLong
      |=> ptrNew == $past(extended_aux_pointer) - 23'h000001 && ptrWrEn)
      else $error("word pre-decrement wrong");
   AST_PREDEC_LONG: assert property (accept && reqMode == 2'h0 && reqLong
      |=> ptrNew == $past(extended_aux_pointer) - 23'h000002)
      else $error("long pre-decrement wrong");
   AST_LINEAR_ADDR: assert property (accept && !circularEn && reqMode != 2'h0
      |=> dataAddr == $past(extended_aux_pointer))
      else $error("post mode address not unmodified pointer");
   AST_SECOND_WORD: assert property (accept && reqLong
      |=> ##1 addrSecond && dataAddr == ($past(dataAddr[0]) ? $past(dataAddr) - 23'h000001
                                         : $past(dataAddr) + 23'h000001))
      else $error("second word address wrong");
   AST_POSTADD_IDX: assert property (accept && reqMode == 2'h1 && !legacy_compat_mode
      |=> ptrNew == $past(extended_aux_pointer) + {7'h00, $past(index_register_zero)})
      else $error("post-add index wrong");
   AST_POSTSUB_IDX: assert property (accept && reqMode == 2'h2 && !legacy_compat_mode
      |=> ptrNew == $past(extended_aux_pointer) - {7'h00, $past(index_register_zero)})
      else $error("post-subtract index wrong");
   AST_POSTADD_AUX: assert property (accept && reqMode == 2'h1 && legacy_compat_mode
      |=> ptrNew == $past(extended_aux_pointer) + $past(extended_aux_register_zero))
      else $error("post-add aux wrong");
   AST_POSTSUB_AUX: assert property (accept && reqMode == 2'h2 && legacy_compat_mode
      |=> ptrNew == $past(extended_aux_pointer) - $past(extended_aux_register_zero))
      else $error("post-subtract aux wrong");
   AST_LONG_BUSY: assert property (accept && reqLong |=> !reqReady ##1 reqReady)
      else $error("long access sequencing wrong");
   AST_POSTADD_UNSCALED: assert property (accept && reqMode == 2'h1 && reqLong
      && !legacy_compat_mode
      |=> ptrNew == $past(extended_aux_pointer) + {7'h00, $past(index_register_zero)})
      else $error("long post-add offset scaled");
   AST_POSTSUB_UNSCALED: assert property (accept && reqMode == 2'h2 && reqLong
      && legacy_compat_mode
      |=> ptrNew == $past(extended_aux_pointer) - $past(extended_aux_register_zero))
      else $error("long post-subtract offset scaled");
   AST_SECOND_NO_WRITE: assert property (addrSecond |-> addrValid && !ptrWrEn)
      else $error("second word rewrote pointer");
   AST_SECOND_HOLDS_PTR: assert property (addrSecond |-> $stable(ptrNew))
      else $error("pointer moved on second word");
   AST_BUSY_REFUSED: assert property (reqValid && !reqReady |=> !ptrWrEn)
      else $error("request taken while busy");
   AST_WORD_PULSE: assert property (accept && !reqLong
      |=> addrValid && ptrWrEn && !addrSecond)
      else $error("word access outputs wrong");
   AST_PREDEC_ADDR: assert property (accept && reqMode == 2'h0 && !circularEn
      |=> dataAddr == ptrNew)
      else $error("pre-decrement address not new pointer");
   AST_CIRC_ADDR: assert property (accept && circularEn && reqMode != 2'h0
      |=> dataAddr == {$past(extended_aux_pointer[`IPMA_PTR_W-1:`IPMA_LOW_W]),
                       $past(extended_aux_pointer[`IPMA_LOW_W-1:0])
                       + $past(circular_buffer_start)})
      else $error("circular address wrong");

   // ----------------------------------------
   // coverage
   // ----------------------------------------
   COV_REFUSED_BUSY: cover property (reqValid && !reqReady);
   COV_PREDEC_LONG: cover property (accept && reqMode == 2'h0 && reqLong);
   COV_POSTADD_LEGACY: cover property (accept && reqMode == 2'h1 && legacy_compat_mode);
   COV_CIRCULAR: cover property (accept && circularEn);
   COV_ODD_SECOND: cover property (addrSecond && !dataAddr[0]);
endmodule

// ==== ipma_map.svh ====
// constants for the indirect pointer-modify address generator
// assumes a 23-bit extended pointer and 16-bit index register
`ifndef IPMA_MAP_SVH
`define IPMA_MAP_SVH
`define IPMA_PTR_W 23
`define IPMA_LOW_W 16
`define IPMA_HIGH_W 7
`define IPMA_STEP_WORD 23'h000001
`define IPMA_STEP_LONG 23'h000002
`define IPMA_PTR_RESET 23'h000000
`define IPMA_MODE_PREDEC 2'h0
`define IPMA_MODE_POSTADD 2'h1
`define IPMA_MODE_POSTSUB 2'h2
`endif

// ==== ipma_pkg.sv ====
// types for the indirect pointer-modify address generator
// assumes ipma_map.svh is on the include path
`include "ipma_map.svh"
package ipma_pkg;
   typedef logic [`IPMA_PTR_W-1:0] ipma_ptr_t;
   typedef enum logic [1:0] {
      IPMA_PREDEC = `IPMA_MODE_PREDEC,
      IPMA_POSTADD = `IPMA_MODE_POSTADD,
      IPMA_POSTSUB = `IPMA_MODE_POSTSUB
   } ipma_mode_t;
   typedef enum logic [1:0] {
      IPMA_IDLE = 2'h0,
      IPMA_SECOND = 2'h1,
      IPMA_FIRST = 2'h3
   } ipma_state_t;
endpackage

// ==== tb_top.sv ====
// testbench for the indirect pointer-modify address generator
// assumes ipma_map.svh and ipma_pkg are compiled first
`timescale 1ns/1ps
`include "ipma_map.svh"
module tb_top
   import ipma_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic reqValid = 1'b0;
   logic reqLong = 1'b0;
   logic legMode = 1'b0;
   logic circEn = 1'b0;
   logic [1:0] reqMode = 2'h0;
   logic [15:0] bufStart = 16'h0000;
   logic [15:0] idxZero = 16'h0000;
   ipma_ptr_t ptrCur = 23'h000000;
   ipma_ptr_t auxZero = 23'h000000;
   logic reqReady, addrValid, addrSecond, ptrWrEn;
   ipma_ptr_t dataAddr, ptrNew;
   int fail_count = 0;
   int checks_done = 0;

   always #4 clk_sys = ~clk_sys;

   ipma_agen ipma_agen_i (.clk_sys(clk_sys), .reset_n(reset_n), .reqValid(reqValid),
      .reqMode(reqMode), .reqLong(reqLong), .legacy_compat_mode(legMode),
      .circularEn(circEn), .circular_buffer_start(bufStart),
      .extended_aux_pointer(ptrCur), .index_register_zero(idxZero),
      .extended_aux_register_zero(auxZero), .reqReady(reqReady), .addrValid(addrValid),
      .addrSecond(addrSecond), .dataAddr(dataAddr), .ptrWrEn(ptrWrEn), .ptrNew(ptrNew));

   // ----------------------------------------
   // compare and verdict
   // ----------------------------------------
   task automatic check(input string what, input ipma_ptr_t seen, input ipma_ptr_t exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // one access: drive, then judge each word
   // ----------------------------------------
   task automatic op(input logic [1:0] m, input logic l, input logic lg, input logic ce,
         input logic [15:0] bs, input logic [15:0] ix, input ipma_ptr_t p,
         input ipma_ptr_t x0);
      ipma_ptr_t np;
      ipma_ptr_t a;
      int n;
      np = (m == 2'h0) ? p - (l ? 23'h000002 : 23'h000001)
         : (m == 2'h1) ? p + (lg ? x0 : {7'h00, ix}) : p - (lg ? x0 : {7'h00, ix});
      a = (m == 2'h0) ? np : p;
      if (ce) a[15:0] = a[15:0] + bs;
      for (n = 0; n < 20 && reqReady !== 1'b1; n++) @(posedge clk_sys);
      if (n == 20) begin
         fail_count++;
         give_verdict();
      end
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqMode <= m;
      reqLong <= l;
      legMode <= lg;
      circEn <= ce;
      bufStart <= bs;
      idxZero <= ix;
      ptrCur <= p;
      auxZero <= x0;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      #1;
      check("addrValid", addrValid, 1'b1);
      check("ptrWrEn", ptrWrEn, 1'b1);
      check("dataAddr", dataAddr, a);
      check("ptrNew", ptrNew, np);
      if (l) begin
         check("reqReady", reqReady, 1'b0);
         @(posedge clk_sys);
         #1;
         check("addrSecond", addrSecond, 1'b1);
         check("secondAddr", dataAddr, a[0] ? a - 23'h000001 : a + 23'h000001);
         check("secondValid", addrValid, 1'b1);
         check("secondWrite", ptrWrEn, 1'b0);
         check("secondPtr", ptrNew, np);
         check("readyAgain", reqReady, 1'b1);
      end else begin
         check("noSecond", addrSecond, 1'b0);
      end
   endtask

   task automatic refuse_mode3;
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqMode <= 2'h3;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      #1;
      check("addrValid", addrValid, 1'b0);
      check("noWrite", ptrWrEn, 1'b0);
   endtask

   task automatic refuse_busy;
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqMode <= 2'h1;
      reqLong <= 1'b1;
      legMode <= 1'b0;
      circEn <= 1'b0;
      idxZero <= 16'h0010;
      ptrCur <= 23'h000200;
      @(posedge clk_sys);
      reqLong <= 1'b0;
      ptrCur <= 23'h000300;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      #1;
      check("busyPtr", ptrNew, 23'h000210);
      check("busyWrite", ptrWrEn, 1'b0);
      check("busySecond", dataAddr, 23'h000201);
      @(posedge clk_sys);
      #1;
      check("busyIdle", addrValid, 1'b0);
      check("busyKept", ptrNew, 23'h000210);
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      check("resetAddr", dataAddr, 23'h000000);
      check("resetReady", reqReady, 1'b0);
      op(2'h0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 23'h000010, 23'h000000);
      op(2'h0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 23'h000000, 23'h000000);
      op(2'h0, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000, 23'h000013, 23'h000000);
      op(2'h1, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h8005, 23'h400100, 23'h000777);
      op(2'h1, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0003, 23'h400100, 23'h000777);
      op(2'h2, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0009, 23'h000004, 23'h000777);
      op(2'h1, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0005, 23'h000100, 23'h012345);
      op(2'h2, 1'b1, 1'b1, 1'b0, 16'h0000, 16'h0005, 23'h200101, 23'h000007);
      op(2'h0, 1'b0, 1'b0, 1'b1, 16'hFFF0, 16'h0000, 23'h450020, 23'h000000);
      op(2'h2, 1'b1, 1'b0, 1'b1, 16'h0102, 16'h0004, 23'h7F0010, 23'h000000);
      refuse_mode3();
      refuse_busy();
      give_verdict();
   end
endmodule
